// ### rtl/servo_homing_mode_sequencer.sv
// Operating mode selection, limit switch homing and multi-drive command store
//
// Function
// - Left advanced homing moves left until switch active longer than 1 ms.
// - After debounce, reverse at one fifth speed until the switch releases.
// - Advanced homing then moves on until the next encoder index pulse.
// - Completed homing switches the mode code to homing finished, 20.
// - Mode 16 mirrors the advanced sequence, searching rightward first.
// - Mode 17 searches left and backs off, no index move.
// - Mode 18 searches right and backs off, no index move.
// - Mode 20 is entered only from homing modes at completion.
// - Mode 101 clears the current position to zero.
// - Mode 128 regulates motor current to the commanded value.
// - 129 is position with planner, 130 speed with planner.
// - 132 is speed without planner, 133 position without planner.
// - Mode 134 is closed-loop stepper; holding current drops to 20 percent.
// - Setup command holds mode and torque within 600 mNm per drive.
// - Special code 0 does nothing, 5 clears that slave's last error.
// - Target command holds signed 32-bit positions for all nine drives.
// - Mode 15 starts left homing; switch polarity is configurable.
// - Mode 0 de-energizes the motor windings.
// - A fault reports mode -1 and keeps a readable last error.
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`include "servo_seq_defines.svh"
module servo_homing_mode_sequencer
    import servo_seq_pkg::*;
#(
    parameter int DEBOUNCE_CYC = `DEBOUNCE_NS / `CLK_NS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic limit_sw,
    input wire logic index_pulse,
    input wire logic enc_step,
    input wire logic enc_dir,
    input wire logic at_target,
    input wire logic fault,
    input wire logic [7:0] fault_code,
    output logic energize_q,
    output ctrl_sel_t ctrl_sel_q,
    output logic planner_bypassed,
    output logic motion_en_q,
    output logic dir_right_q,
    output logic [15:0] speed_out_q,
    output logic [15:0] current_out_q,
    output logic [31:0] position_q,
    output logic [15:0] mode_q,
    output logic [8:0][31:0] setup_word_q,
    output logic [8:0][31:0] target_word_q,
    output logic setup_send_q,
    output logic target_send_q,
    output logic [7:0] slave_err_clear_q
);
    // ********************
    // Bus decode
    // ********************
    logic wr_en;
    logic rd_en;
    logic hit;
    logic setup_hit;
    logic target_hit;
    logic [3:0] md_idx;
    logic [15:0] speed_q;
    logic [15:0] current_q;
    logic [15:0] nominal_q;
    logic pol_high_q;
    logic [7:0] last_err_q;
    logic [31:0] rd_d;
    home_st_t st_q;
    logic [23:0] cnt_q;
    logic sw_act;
    logic home_en;
    logic mirrored;
    logic use_index;
    logic home_done;
    logic send_setup;
    logic send_target;
    logic [15:0] master_sel;
    logic [15:0] sw_mode;
    logic sw_mode_wr;

    // Access phase with pready high is the one commit edge
    assign wr_en = psel && penable && pready && pwrite && !pslverr;
    assign rd_en = psel && !penable;
    assign md_idx = paddr[5:2];
    assign setup_hit = (paddr[7:6] == 2'b01) && (md_idx < 4'd9) && (paddr[1:0] == 2'b00);
    assign target_hit = (paddr[7:6] == 2'b10) && (md_idx < 4'd9) && (paddr[1:0] == 2'b00);

    // Saturate a signed 12-bit torque field; its own sign bit decides the direction
    function automatic logic [`TQ_MSB:0] clamp_tq(input logic [`TQ_MSB:0] v);
        logic signed [`TQ_MSB:0] s;
        s = $signed(v);
        if (s > `TQ_LIMIT) begin
            return 12'sd600;
        end else if (s < -`TQ_LIMIT) begin
            return -12'sd600;
        end
        return v[`TQ_MSB:0];
    endfunction : clamp_tq

    // Read mux; unmapped addresses flag an error
    always_comb begin
        hit = 1'b1;
        rd_d = 32'h0000_0000;
        case (paddr)
            `OFS_MODE: rd_d = {16'h0000, mode_q};
            `OFS_SPEED: rd_d = {16'h0000, speed_q};
            `OFS_CURRENT: rd_d = {16'h0000, current_q};
            `OFS_NOMINAL: rd_d = {16'h0000, nominal_q};
            `OFS_CONFIG: rd_d = {31'h0, pol_high_q};
            `OFS_STATUS: rd_d = {26'h0, at_target, sw_act, st_q, dir_right_q, motion_en_q};
            `OFS_POSITION: rd_d = position_q;
            `OFS_LAST_ERR: rd_d = {24'h0, last_err_q};
            `OFS_MD_SEND: rd_d = 32'h0000_0000;
            default: begin
                if (setup_hit) begin
                    rd_d = setup_word_q[md_idx];
                end else if (target_hit) begin
                    rd_d = target_word_q[md_idx];
                end else begin
                    hit = 1'b0;
                end
            end
        endcase
    end

    // Answer one cycle after setup; zero wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= rd_en;
            pslverr <= rd_en && !hit;
            if (rd_en && !pwrite) begin
                prdata <= rd_d;
            end
        end
    end

    // ********************
    // Software settings
    // ********************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            speed_q <= `RST_SPEED;
            current_q <= 16'h0000;
            nominal_q <= `RST_NOMINAL;
            pol_high_q <= 1'b0;
        end else if (wr_en) begin
            case (paddr)
                `OFS_SPEED: speed_q <= pwdata[15:0];
                `OFS_CURRENT: current_q <= pwdata[15:0];
                `OFS_NOMINAL: nominal_q <= pwdata[15:0];
                `OFS_CONFIG: pol_high_q <= pwdata[0];
                default: ;
            endcase
        end
    end

    // Multi-drive word stores; torque saturated on entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            setup_word_q <= '0;
            target_word_q <= '0;
        end else if (wr_en && setup_hit) begin
            setup_word_q[md_idx] <= {pwdata[31:12], clamp_tq(pwdata[`TQ_MSB:0])};
        end else if (wr_en && target_hit) begin
            target_word_q[md_idx] <= pwdata;
        end
    end

    assign send_setup = wr_en && (paddr == `OFS_MD_SEND) && pwdata[0];
    assign send_target = wr_en && (paddr == `OFS_MD_SEND) && pwdata[1];

    // Send strobes and per-slave error clear pulses toward the CAN link
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            setup_send_q <= 1'b0;
            target_send_q <= 1'b0;
        end else begin
            setup_send_q <= send_setup;
            target_send_q <= send_target;
        end
    end

    // Only code 5 acts; 0 and undefined codes are ignored
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_slave
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    slave_err_clear_q[gi] <= 1'b0;
                end else begin
                    slave_err_clear_q[gi] <= send_setup &&
                        (setup_word_q[gi+1][`SPC_MSB:`SPC_LSB] == `SPC_CLR_ERR);
                end
            end
        end
    endgenerate

    // ********************
    // Homing sequencer
    // ********************
    assign sw_act = pol_high_q ? limit_sw : !limit_sw;
    assign home_en = (mode_q == `M_HOME_LA) || (mode_q == `M_HOME_RA) ||
        (mode_q == `M_HOME_LS) || (mode_q == `M_HOME_RS);
    assign mirrored = (mode_q == `M_HOME_RA) || (mode_q == `M_HOME_RS);
    assign use_index = (mode_q == `M_HOME_LA) || (mode_q == `M_HOME_RA);
    assign home_done = home_en && (((st_q == H_BACK) && !sw_act && !use_index) ||
        ((st_q == H_INDEX) && index_pulse));

    // Debounce counts consecutive active samples only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= H_IDLE;
            cnt_q <= 24'h000000;
        end else if (!home_en) begin
            st_q <= H_IDLE;
            cnt_q <= 24'h000000;
        end else begin
            case (st_q)
                H_IDLE: begin
                    st_q <= H_SEARCH;
                    cnt_q <= 24'h000000;
                end
                H_SEARCH: begin
                    if (!sw_act) begin
                        cnt_q <= 24'h000000;
                    end else if (cnt_q >= 24'(DEBOUNCE_CYC)) begin
                        st_q <= H_BACK;
                    end else begin
                        cnt_q <= cnt_q + 24'h000001;
                    end
                end
                H_BACK: begin
                    if (!sw_act) begin
                        st_q <= use_index ? H_INDEX : H_IDLE;
                    end
                end
                H_INDEX: begin
                    if (index_pulse) begin
                        st_q <= H_IDLE;
                    end
                end
                default: st_q <= H_IDLE;
            endcase
        end
    end

    // ********************
    // Mode code
    // ********************
    assign master_sel = {{7{setup_word_q[0][`SEL_MSB]}}, setup_word_q[0][`SEL_MSB:`SEL_LSB]};
    assign sw_mode_wr = (wr_en && (paddr == `OFS_MODE)) || send_setup;
    assign sw_mode = send_setup ? master_sel : pwdata[15:0];

    // Fault beats homing completion beats software; software cannot pick 20
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= `M_OFF;
        end else if (fault) begin
            mode_q <= `M_ERR;
        end else if (home_done) begin
            mode_q <= `M_HOME_DONE;
        end else if (sw_mode_wr && (sw_mode != `M_HOME_DONE)) begin
            mode_q <= sw_mode;
        end
    end

    // Last error: a new fault wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_err_q <= 8'h00;
        end else if (fault) begin
            last_err_q <= fault_code;
        end else if (wr_en && (paddr == `OFS_LAST_ERR)) begin
            last_err_q <= 8'h00;
        end
    end

    // Position tracks encoder steps; held at zero in set-zero mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            position_q <= 32'h0000_0000;
        end else if (mode_q == `M_ZERO) begin
            position_q <= 32'h0000_0000;
        end else if (enc_step) begin
            position_q <= enc_dir ? position_q + 32'h1 : position_q - 32'h1;
        end
    end

    // ********************
    // Drive outputs
    // ********************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            energize_q <= 1'b0;
            ctrl_sel_q <= CTL_OFF;
            planner_bypassed <= 1'b0;
            motion_en_q <= 1'b0;
            dir_right_q <= 1'b0;
            speed_out_q <= 16'h0000;
            current_out_q <= 16'h0000;
        end else begin
            energize_q <= 1'b1;
            planner_bypassed <= 1'b0;
            motion_en_q <= 1'b0;
            dir_right_q <= 1'b0;
            speed_out_q <= speed_q;
            current_out_q <= current_q;
            case (mode_q)
                `M_HOME_LA, `M_HOME_RA, `M_HOME_LS, `M_HOME_RS: begin
                    ctrl_sel_q <= CTL_HOMING;
                    motion_en_q <= (st_q != H_IDLE);
                    // Index move keeps the back-off direction, away from the switch
                    dir_right_q <= mirrored ^ ((st_q == H_BACK) || (st_q == H_INDEX));
                    if (st_q == H_BACK) begin
                        speed_out_q <= speed_q / `SLOW_DIV;
                    end
                end
                `M_HOME_DONE, `M_ZERO: ctrl_sel_q <= CTL_POSITION;
                `M_CURRENT: ctrl_sel_q <= CTL_CURRENT;
                `M_POS_PP: ctrl_sel_q <= CTL_POSITION;
                `M_SPD_PP: ctrl_sel_q <= CTL_SPEED;
                `M_SPD_NPP: begin
                    ctrl_sel_q <= CTL_SPEED;
                    planner_bypassed <= 1'b1;
                end
                `M_POS_NPP: begin
                    ctrl_sel_q <= CTL_POSITION;
                    planner_bypassed <= 1'b1;
                end
                `M_STEPPER: begin
                    ctrl_sel_q <= CTL_STEPPER;
                    current_out_q <= at_target ? nominal_q / `SLOW_DIV : nominal_q;
                end
                default: begin
                    // Off, error and unsupported codes leave the shaft free
                    ctrl_sel_q <= CTL_OFF;
                    energize_q <= 1'b0;
                end
            endcase
        end
    end

    // ********************
    // Assertions
    // ********************
    property p_debounce_hold;
        @(posedge pclk) disable iff (!presetn)
        (st_q == H_SEARCH && home_en && !fault && !sw_mode_wr && !sw_act)
            |=> (cnt_q == 24'h0 && st_q == H_SEARCH);
    endproperty
    a_debounce_hold: assert property (p_debounce_hold) else $error("debounce not restarted");

    property p_back_after_debounce;
        @(posedge pclk) disable iff (!presetn)
        (st_q == H_SEARCH && $past(st_q) == H_SEARCH) |-> (cnt_q <= 24'(DEBOUNCE_CYC));
    endproperty
    a_back_after_debounce: assert property (p_back_after_debounce) else $error("debounce overrun");

    property p_back_slow;
        @(posedge pclk) disable iff (!presetn)
        (st_q == H_BACK && home_en) ##1 (st_q == H_BACK && home_en)
            |-> (speed_out_q == speed_q / `SLOW_DIV && dir_right_q == !mirrored);
    endproperty
    a_back_slow: assert property (p_back_slow) else $error("back-off speed or dir wrong");

    property p_done_mode;
        @(posedge pclk) disable iff (!presetn)
        (home_done && !fault) |=> (mode_q == `M_HOME_DONE && st_q == H_IDLE);
    endproperty
    a_done_mode: assert property (p_done_mode) else $error("homing end not reported");

    property p_done_only_homing;
        @(posedge pclk) disable iff (!presetn)
        (mode_q == `M_HOME_DONE && $past(mode_q) != `M_HOME_DONE) |-> $past(home_done);
    endproperty
    a_done_only_homing: assert property (p_done_only_homing) else $error("mode 20 entered");

    property p_zero_pos;
        @(posedge pclk) disable iff (!presetn)
        (mode_q == `M_ZERO) |=> (position_q == 32'h0);
    endproperty
    a_zero_pos: assert property (p_zero_pos) else $error("position not cleared");

    property p_hold_current;
        @(posedge pclk) disable iff (!presetn)
        (mode_q == `M_STEPPER && at_target) |=>
            (current_out_q == $past(nominal_q) / `SLOW_DIV && ctrl_sel_q == CTL_STEPPER);
    endproperty
    a_hold_current: assert property (p_hold_current) else $error("holding current wrong");

    property p_npp_speed;
        @(posedge pclk) disable iff (!presetn)
        (mode_q == `M_SPD_NPP) |=> (planner_bypassed && ctrl_sel_q == CTL_SPEED);
    endproperty
    a_npp_speed: assert property (p_npp_speed) else $error("speed bypass wrong");

    property p_fault_mode;
        @(posedge pclk) disable iff (!presetn)
        fault |=> (mode_q == `M_ERR && last_err_q == $past(fault_code)) ##1 !energize_q;
    endproperty
    a_fault_mode: assert property (p_fault_mode) else $error("fault not reported");

    property p_torque_window;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && setup_hit) |=>
            ($signed(setup_word_q[$past(md_idx)][`TQ_MSB:0]) <= 12'sd600) &&
            ($signed(setup_word_q[$past(md_idx)][`TQ_MSB:0]) >= -12'sd600);
    endproperty
    a_torque_window: assert property (p_torque_window) else $error("torque out of range");

    property p_special_clear;
        @(posedge pclk) disable iff (!presetn)
        (send_setup && setup_word_q[1][`SPC_MSB:`SPC_LSB] == `SPC_CLR_ERR)
            |=> slave_err_clear_q[0] ##1 !slave_err_clear_q[0] || send_setup;
    endproperty
    a_special_clear: assert property (p_special_clear) else $error("slave clear missing");

    property p_off_free;
        @(posedge pclk) disable iff (!presetn)
        (mode_q == `M_OFF) |=> !energize_q;
    endproperty
    a_off_free: assert property (p_off_free) else $error("motor energized in mode 0");
endmodule : servo_homing_mode_sequencer

// ### rtl/servo_seq_defines.svh
// Register offsets, field positions, mode codes and timing for the homing sequencer
`ifndef SERVO_SEQ_DEFINES_SVH
`define SERVO_SEQ_DEFINES_SVH
// ********************
// Register byte offsets
// ********************
`define OFS_MODE 8'h00
`define OFS_SPEED 8'h04
`define OFS_CURRENT 8'h08
`define OFS_NOMINAL 8'h0c
`define OFS_CONFIG 8'h10
`define OFS_STATUS 8'h14
`define OFS_POSITION 8'h18
`define OFS_LAST_ERR 8'h1c
`define OFS_MD_SEND 8'h20
`define OFS_SETUP_BASE 8'h40
`define OFS_TARGET_BASE 8'h80
`define MD_WORDS 9
// ********************
// Field positions
// ********************
`define TQ_MSB 11
`define SEL_LSB 16
`define SEL_MSB 24
`define SPC_LSB 28
`define SPC_MSB 31
`define TQ_LIMIT 16'sd600
`define SPC_NONE 4'h0
`define SPC_CLR_ERR 4'h5
// ********************
// Operating mode codes
// ********************
`define M_ERR 16'hffff
`define M_OFF 16'h0000
`define M_HOME_LA 16'h000f
`define M_HOME_RA 16'h0010
`define M_HOME_LS 16'h0011
`define M_HOME_RS 16'h0012
`define M_HOME_DONE 16'h0014
`define M_ZERO 16'h0065
`define M_CURRENT 16'h0080
`define M_POS_PP 16'h0081
`define M_SPD_PP 16'h0082
`define M_SPD_NPP 16'h0084
`define M_POS_NPP 16'h0085
`define M_STEPPER 16'h0086
// ********************
// Reset values and timing
// ********************
`define RST_SPEED 16'h0000
`define RST_NOMINAL 16'h0000
`define CLK_NS 40
`define DEBOUNCE_NS 1000000
`define SLOW_DIV 16'd5
`endif

// ### rtl/servo_seq_pkg.sv
// Types shared by the homing and mode sequencer
package servo_seq_pkg;
    typedef enum logic [2:0] {
        CTL_OFF,
        CTL_CURRENT,
        CTL_POSITION,
        CTL_SPEED,
        CTL_STEPPER,
        CTL_HOMING
    } ctrl_sel_t;
    typedef enum logic [1:0] {
        H_IDLE,
        H_SEARCH,
        H_BACK,
        H_INDEX
    } home_st_t;
endpackage : servo_seq_pkg

// ### sim/motor_env_model.sv
// Motor, limit switch and encoder stand-in around the homing outputs
`timescale 1ns/1ns
module motor_env_model #(
    parameter int LIM = 20
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic motion_en_q,
    input wire logic dir_right_q,
    input wire logic pol_high,
    input wire logic bounce,
    output logic limit_sw,
    output logic index_pulse,
    output logic enc_step,
    output logic enc_dir
);
    int pos;
    logic act;
    // Shaft moves one count a cycle; recentred once motion stops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos <= 0;
        end else if (motion_en_q) begin
            pos <= dir_right_q ? pos + 1 : pos - 1;
        end else begin
            pos <= 0;
        end
    end
    // Switch at both ends; a lone blip off the index spot models chatter
    assign act = (pos >= LIM) || (pos <= -LIM) || (bounce && (pos == LIM - 5 || pos == 5 - LIM));
    assign limit_sw = pol_high ? act : !act;
    assign index_pulse = motion_en_q && (pos % 8 == 0);
    assign enc_step = motion_en_q;
    assign enc_dir = dir_right_q;
endmodule : motor_env_model

// ### sim/tb_servo_homing_mode_sequencer.sv
// Self-checking bench for the homing and mode sequencer
`timescale 1ns/1ns
`include "servo_seq_defines.svh"
module tb_servo_homing_mode_sequencer
    import servo_seq_pkg::*;
;
    localparam int DEB = 8;
    localparam logic [15:0] CODES [9] = '{`M_OFF, 16'h0008, `M_ZERO, `M_CURRENT, `M_POS_PP,
        `M_SPD_PP, `M_SPD_NPP, `M_POS_NPP, `M_STEPPER};
    localparam ctrl_sel_t SELS [9] = '{CTL_OFF, CTL_OFF, CTL_POSITION, CTL_CURRENT, CTL_POSITION,
        CTL_SPEED, CTL_SPEED, CTL_POSITION, CTL_STEPPER};
    localparam logic [8:0] BYP = 9'h0c0;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00, fault_code = 8'h00, slave_err_clear_q;
    logic [31:0] pwdata = 32'h0, prdata, position_q, rd;
    logic pready, pslverr, limit_sw, index_pulse, enc_step, enc_dir, err;
    logic at_target = 0, fault = 0, pol = 0, bounce = 0;
    logic energize_q, planner_bypassed, motion_en_q, dir_right_q, setup_send_q, target_send_q;
    ctrl_sel_t ctrl_sel_q;
    logic [15:0] speed_out_q, current_out_q, mode_q;
    logic [8:0][31:0] setup_word_q, target_word_q;
    int failures = 0, num_checks = 0, cyc = 0;
    always #20 pclk = ~pclk;
    servo_homing_mode_sequencer #(.DEBOUNCE_CYC(DEB)) uut (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .limit_sw, .index_pulse, .enc_step,
        .enc_dir, .at_target, .fault, .fault_code, .energize_q, .ctrl_sel_q, .planner_bypassed,
        .motion_en_q, .dir_right_q, .speed_out_q, .current_out_q, .position_q, .mode_q,
        .setup_word_q, .target_word_q, .setup_send_q, .target_send_q, .slave_err_clear_q);
    motor_env_model motor (.pclk, .presetn, .motion_en_q, .dir_right_q, .pol_high(pol), .bounce,
        .limit_sw, .index_pulse, .enc_step, .enc_dir);
    task automatic wrap_up;
        if (failures == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    // Bus cycle: hold the request until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk({31'h0, pready}, 1, "no pready");
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(0, a, 32'h0);
        chk(rd, exp, what);
    endtask : rchk
    task automatic pulse(input logic tgt);
        int n;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while ((tgt ? target_send_q : setup_send_q) !== 1'b1 && n < 4);
        chk({31'h0, tgt ? target_send_q : setup_send_q}, 1, "send pulse");
    endtask : pulse
    // Homing run watched each cycle against the reference sequence
    task automatic home(input int m);
        int spd, cnt, rel, ph, n;
        logic right, act, idx;
        right = (m == 16 || m == 18);
        spd = $urandom_range(100, 60000);
        pol <= m[0];
        bounce <= (m == 15);
        apb(1, `OFS_CONFIG, {31'h0, m[0]});
        apb(1, `OFS_SPEED, 32'(spd));
        apb(1, `OFS_MODE, 32'(m));
        {cnt, rel, ph, idx} = '0;
        for (n = 0; n < 400; n++) begin
            @(negedge pclk);
            if (mode_q === `M_HOME_DONE) break;
            act = (limit_sw === pol);
            if (ph == 0 && motion_en_q === 1'b1 && dir_right_q !== right) begin
                ph = 1;
                chk(cnt >= DEB + 1, 1, "debounce");
                chk(speed_out_q, 32'(spd / 5), "slow speed");
            end else if (ph == 0) begin
                cnt = act ? cnt + 1 : 0;
            end else begin
                if (motion_en_q === 1'b1) chk(dir_right_q, !right, "reverse dir");
                if (!act) begin
                    rel++;
                    idx |= index_pulse;
                end
            end
        end
        chk(mode_q, `M_HOME_DONE, "done");
        if (m <= 16) chk(idx, 1, "index");
        else chk(rel <= 4, 1, "no index");
        rchk(`OFS_MODE, 32'h14, "mode reg");
    endtask : home
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 40000) begin
            failures++;
            wrap_up();
        end
    end
    // ****************
    // Main sequence
    // ****************
    initial begin
        logic [31:0] w, nom, cur;
        logic [31:0] expw [9];
        logic [11:0] tq;
        logic [3:0] sp;
        logic [7:0] mask;
        int s;
        void'($urandom(20853));
        repeat (2) @(posedge pclk);
        presetn <= 1;
        rchk(`OFS_MODE, 32'h0, "reset mode");
        chk(energize_q, 0, "off");
        apb(1, `OFS_MODE, 32'h14);
        rchk(`OFS_MODE, 32'h0, "mode 20 refused");
        rchk(8'h3c, 32'h0, "unmapped");
        chk(err, 1, "slverr");
        for (int m = 15; m <= 18; m++) home(m);
        w = $urandom_range(1, 255);
        @(posedge pclk);
        fault <= 1;
        fault_code <= w[7:0];
        @(posedge pclk);
        fault <= 0;
        rchk(`OFS_MODE, 32'h0000ffff, "fault mode");
        rchk(`OFS_LAST_ERR, w, "last err");
        apb(1, `OFS_LAST_ERR, 32'h0);
        rchk(`OFS_LAST_ERR, 32'h0, "err cleared");
        // Setup command: random torques, some cleared errors
        mask = '0;
        for (int i = 0; i < 9; i++) begin
            tq = 12'($urandom);
            s = tq[11] ? int'(tq) - 4096 : int'(tq);
            s = s > 600 ? 600 : (s < -600 ? -600 : s);
            sp = (i > 0 && $urandom_range(0, 1) == 1) ? 4'h5 : 4'h0;
            if (sp == 4'h5) mask[i - 1] = 1'b1;
            apb(1, `OFS_SETUP_BASE + 8'(4 * i), {sp, 3'h0, 9'h085, 4'h0, tq});
            expw[i] = {sp, 3'h0, 9'h085, 4'h0, 12'(s)};
        end
        apb(1, `OFS_MD_SEND, 32'h1);
        pulse(0);
        chk(slave_err_clear_q, mask, "err clear");
        chk(mode_q, 32'h85, "master mode");
        for (int i = 0; i < 9; i++) chk(setup_word_q[i], expw[i], "setup word");
        rchk(`OFS_MD_SEND, 32'h0, "send reads 0");
        for (int i = 0; i < 9; i++) begin
            expw[i] = $urandom;
            apb(1, `OFS_TARGET_BASE + 8'(4 * i), expw[i]);
        end
        apb(1, `OFS_MD_SEND, 32'h2);
        pulse(1);
        for (int i = 0; i < 9; i++) chk(target_word_q[i], expw[i], "target word");
        // Off, an unsupported code and modes 101 to 134 against the reference table
        nom = $urandom_range(0, 65535);
        cur = $urandom_range(0, 65535);
        apb(1, `OFS_NOMINAL, nom);
        apb(1, `OFS_CURRENT, cur);
        for (int k = 0; k < 9; k++) begin
            apb(1, `OFS_MODE, {16'h0, CODES[k]});
            repeat (2) @(negedge pclk);
            chk(ctrl_sel_q, SELS[k], "ctrl sel");
            chk(planner_bypassed, BYP[k], "bypass");
            chk(energize_q, SELS[k] != CTL_OFF, "energize");
            if (k == 2) chk(position_q, 32'h0, "zeroed");
            if (k == 3) chk(current_out_q, cur, "current");
        end
        @(posedge pclk);
        at_target <= 1;
        repeat (2) @(negedge pclk);
        chk(current_out_q, nom / 5, "holding");
        @(posedge pclk);
        at_target <= 0;
        repeat (2) @(negedge pclk);
        chk(current_out_q, nom, "nominal");
        wrap_up();
    end
endmodule : tb_servo_homing_mode_sequencer
